// File: rtl/tme_pkg.sv
// Constants shared by the trigger mapping and encoder block.
// Assumes a 20 MHz pclk and an APB register bus with 32-bit data.
package tme_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int TME_NLINES = 8;
  localparam int TME_NFILT = 12;
  localparam int TME_FLEN_W = 8;
  // ----------------------------------------------------------------
  // Register offsets (bit 6 of the address selects the port alias)
  // ----------------------------------------------------------------
  localparam logic [5:0] TME_OFS_LINE_CFG = 6'h00;
  localparam logic [5:0] TME_OFS_LINE_LEVEL = 6'h04;
  localparam logic [5:0] TME_OFS_LINE_SRC = 6'h08;
  localparam logic [5:0] TME_OFS_LINE_STATE = 6'h0c;
  localparam logic [5:0] TME_OFS_TRIG_SEL = 6'h10;
  localparam logic [5:0] TME_OFS_ENC_CTRL = 6'h14;
  localparam logic [5:0] TME_OFS_ENC_DIV = 6'h18;
  localparam logic [5:0] TME_OFS_POS_LO = 6'h1c;
  localparam logic [5:0] TME_OFS_POS_HI = 6'h20;
  localparam logic [5:0] TME_OFS_FILT_LEN = 6'h24;
  localparam int TME_PORT_BIT = 6;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TME_CFG_DIR_LSB = 0;
  localparam int TME_CFG_INV_LSB = 8;
  localparam int TME_CFG_FALL_LSB = 16;
  localparam int TME_CFG_FILT_LSB = 24;
  localparam int TME_SEL_EN_BIT = 3;
  localparam int TME_ENC_EN_BIT = 0;
  localparam int TME_ENC_CLR_BIT = 1;
  localparam int TME_ENC_DIFF_BIT = 2;
  localparam int TME_ENC_FILT_BIT = 3;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] TME_RST_LINE_CFG = 32'h0000_0000;
  localparam logic [7:0] TME_RST_LEVEL = 8'h00;
  localparam logic [23:0] TME_RST_SRC = 24'h00_0000;
  localparam logic [3:0] TME_RST_TRIG_SEL = 4'h0;
  localparam logic [3:0] TME_RST_ENC_CTRL = 4'h0;
  localparam logic [31:0] TME_RST_ENC_DIV = 32'h0000_0001;
  localparam logic [7:0] TME_RST_FILT_LEN = 8'h04;
  // ----------------------------------------------------------------
  // Output source codes, three bits per line
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TME_SRC_LEVEL = 3'b000,
    TME_SRC_TIM0 = 3'b001,
    TME_SRC_TIM1 = 3'b010,
    TME_SRC_STAT0 = 3'b011,
    TME_SRC_STAT1 = 3'b100,
    TME_SRC_ENC = 3'b101
  } tme_src_type;
endpackage

// File: rtl/tme_filt_if.sv
// Carrier between the block top and one input noise filter.
// Assumes all signals are on pclk except raw, which is asynchronous.
`timescale 1ns/1ps
interface tme_filt_if;
  logic raw;
  logic en;
  logic [7:0] len;
  logic clean;
  modport filt (input raw, input en, input len, output clean);
  modport user (output raw, output en, output len, input clean);
endinterface

// File: rtl/tme_filt.sv
// One input noise filter: two-stage synchroniser, then a stability count.
// Assumes raw may change at any time relative to pclk.
`timescale 1ns/1ps
module tme_filt
  import tme_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Filter carrier
  tme_filt_if.filt fio
);
  logic sync1_reg;
  logic sync2_reg;
  logic clean_reg;
  logic [7:0] cnt_reg;

  // ----------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------
  // Only the second stage reads the first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= fio.raw;
      sync2_reg <= sync1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Stability filter
  // ----------------------------------------------------------------
  // A change must persist len+1 cycles; shorter glitches are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clean_reg <= 1'b0;
      cnt_reg <= 8'h00;
    end else if (!fio.en || sync2_reg == clean_reg) begin
      clean_reg <= sync2_reg;
      cnt_reg <= 8'h00;
    end else if (cnt_reg >= fio.len) begin
      clean_reg <= sync2_reg;
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  assign fio.clean = clean_reg;
endmodule

// File: rtl/tme_top.sv
// Trigger line mapping, acquisition start detection and encoder position.
// Assumes pclk at 20 MHz, APB slave, line and encoder pins asynchronous,
// timing pulses and status inputs synchronous to pclk.
// Contract
// - Each line may start acquisition on rising or falling edge.
// - Each line can be a digital output at a programmed level.
// - Per-line selector puts timing pulses or status signals on a line.
// - Seven sync bus lines plus one external line, all usable together.
// - Polarity and direction programmable per line.
// - Both ports share all lines; each may configure, read, drive.
// - Each line takes the latest write from either port.
// - Noise filter on every line input.
// - Decode quadrature phases from differential or single-ended inputs.
// - Absolute encoder position held in a 64-bit counter.
// - Pulse train gives one pulse per programmed number of ticks.
// - Software can read the position counter at any time.
// - Noise filter on both encoder phase inputs.
`timescale 1ns/1ps
module tme_top
  import tme_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Trigger lines: bits 6..0 sync bus, bit 7 external
  input wire logic [7:0] line_in,
  output logic [7:0] line_out,
  output logic [7:0] line_oe,
  // Timing generator pulses and board status, one per port
  input wire logic [1:0] timing_pulse,
  input wire logic [1:0] status_in,
  // Encoder phases
  input wire logic enc_a_diff,
  input wire logic enc_b_diff,
  input wire logic enc_a_se,
  input wire logic enc_b_se,
  // Results
  output logic [1:0] acq_start,
  output logic pulse_train
);
  // ----------------------------------------------------------------
  // Registers and internal state
  // ----------------------------------------------------------------
  logic [31:0] line_cfg_reg, enc_div_reg, pos_hi_snap_reg, div_cnt_reg, prdata_reg;
  logic [7:0] level_reg, filt_len_reg, pol_prev_reg, line_out_reg, line_oe_reg;
  logic [23:0] src_reg;
  logic [3:0] enc_ctrl_reg, trig_sel_reg [2];
  logic [63:0] pos_reg;
  logic [1:0] ab_prev_reg, acq_start_reg;
  logic pready_reg, pslverr_reg, pulse_train_reg;

  logic [7:0] dir, inv, fall, fen, line_pol, drive_val;
  logic [TME_NFILT-1:0] raw_vec, en_vec, clean_vec;
  logic [1:0] hit, ab_now;
  logic tick, up, bad, setup, wr, port, rd_ok;
  logic [5:0] ofs;
  logic [31:0] div_m1, rd_mux;

  assign dir = line_cfg_reg[TME_CFG_DIR_LSB +: 8];
  assign inv = line_cfg_reg[TME_CFG_INV_LSB +: 8];
  assign fall = line_cfg_reg[TME_CFG_FALL_LSB +: 8];
  assign fen = line_cfg_reg[TME_CFG_FILT_LSB +: 8];

  // ----------------------------------------------------------------
  // Input filters: 8 lines, then diff A, diff B, single A, single B
  // ----------------------------------------------------------------
  assign raw_vec = {enc_b_se, enc_a_se, enc_b_diff, enc_a_diff, line_in};
  assign en_vec = {{4{enc_ctrl_reg[TME_ENC_FILT_BIT]}}, fen};

  tme_filt_if fif [TME_NFILT] ();
  genvar g;
  generate
    for (g = 0; g < TME_NFILT; g++) begin : gen_filt
      assign fif[g].raw = raw_vec[g];
      assign fif[g].en = en_vec[g];
      assign fif[g].len = filt_len_reg;
      assign clean_vec[g] = fif[g].clean;
      tme_filt u_filt (
        .pclk(pclk),
        .presetn(presetn),
        .fio(fif[g])
      );
    end
  endgenerate

  // Polarity is corrected after filtering, so edges see clean levels
  assign line_pol = clean_vec[7:0] ^ inv;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Either alias reaches the same shared line registers
  assign port = paddr[TME_PORT_BIT];
  assign ofs = paddr[5:0];
  assign setup = psel && !penable;
  assign wr = psel && penable && pready_reg && pwrite && rd_ok;
  assign rd_ok = (paddr[31:7] == 25'h000_0000) && (ofs <= TME_OFS_FILT_LEN) &&
                 (ofs[1:0] == 2'b00);

  // Read mux; the position high word comes from the snapshot
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (ofs)
      TME_OFS_LINE_CFG: rd_mux = line_cfg_reg;
      TME_OFS_LINE_LEVEL: rd_mux = {24'h00_0000, level_reg};
      TME_OFS_LINE_SRC: rd_mux = {8'h00, src_reg};
      TME_OFS_LINE_STATE: rd_mux = {24'h00_0000, line_pol};
      TME_OFS_TRIG_SEL: rd_mux = {28'h000_0000, trig_sel_reg[port]};
      TME_OFS_ENC_CTRL: rd_mux = {28'h000_0000, enc_ctrl_reg};
      TME_OFS_ENC_DIV: rd_mux = enc_div_reg;
      TME_OFS_POS_LO: rd_mux = pos_reg[31:0];
      TME_OFS_POS_HI: rd_mux = pos_hi_snap_reg;
      TME_OFS_FILT_LEN: rd_mux = {24'h00_0000, filt_len_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Answer one cycle after setup: zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup && !rd_ok;
      if (setup && !pwrite) begin
        prdata_reg <= rd_ok ? rd_mux : 32'h0000_0000;
      end
    end
  end

  // Reading the low word freezes the high word for a coherent 64-bit read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_hi_snap_reg <= 32'h0000_0000;
    end else if (setup && !pwrite && ofs == TME_OFS_POS_LO) begin
      pos_hi_snap_reg <= pos_reg[63:32];
    end
  end

  // ----------------------------------------------------------------
  // Shared line configuration
  // ----------------------------------------------------------------
  // APB serialises both ports, so the latest write simply wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_cfg_reg <= TME_RST_LINE_CFG;
      level_reg <= TME_RST_LEVEL;
      src_reg <= TME_RST_SRC;
      filt_len_reg <= TME_RST_FILT_LEN;
    end else if (wr) begin
      if (ofs == TME_OFS_LINE_CFG) line_cfg_reg <= pwdata;
      if (ofs == TME_OFS_LINE_LEVEL) level_reg <= pwdata[7:0];
      if (ofs == TME_OFS_LINE_SRC) src_reg <= pwdata[23:0];
      if (ofs == TME_OFS_FILT_LEN) filt_len_reg <= pwdata[7:0];
    end
  end

  // Per-port start line selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_sel_reg[0] <= TME_RST_TRIG_SEL;
      trig_sel_reg[1] <= TME_RST_TRIG_SEL;
    end else if (wr && ofs == TME_OFS_TRIG_SEL) begin
      trig_sel_reg[port] <= pwdata[3:0];
    end
  end

  // Encoder control; the clear bit reads back as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enc_ctrl_reg <= TME_RST_ENC_CTRL;
      enc_div_reg <= TME_RST_ENC_DIV;
    end else begin
      enc_ctrl_reg[TME_ENC_CLR_BIT] <= 1'b0;
      if (wr && ofs == TME_OFS_ENC_CTRL) enc_ctrl_reg <= pwdata[3:0];
      if (wr && ofs == TME_OFS_ENC_DIV) enc_div_reg <= pwdata;
    end
  end

  // ----------------------------------------------------------------
  // Line output mapping
  // ----------------------------------------------------------------
  always_comb begin
    drive_val = 8'h00;
    for (int k = 0; k < TME_NLINES; k++) begin
      unique case (src_reg[3*k +: 3])
        TME_SRC_TIM0: drive_val[k] = timing_pulse[0];
        TME_SRC_TIM1: drive_val[k] = timing_pulse[1];
        TME_SRC_STAT0: drive_val[k] = status_in[0];
        TME_SRC_STAT1: drive_val[k] = status_in[1];
        TME_SRC_ENC: drive_val[k] = pulse_train_reg;
        default: drive_val[k] = level_reg[k];
      endcase
    end
  end

  // Output polarity matches the input view of the same line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_out_reg <= 8'h00;
      line_oe_reg <= 8'h00;
    end else begin
      line_out_reg <= drive_val ^ inv;
      line_oe_reg <= dir;
    end
  end

  // ----------------------------------------------------------------
  // Acquisition start detection
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_prev_reg <= 8'h00;
    end else begin
      pol_prev_reg <= line_pol;
    end
  end

  // Edge chosen per line, enable and line chosen per port
  always_comb begin
    logic [2:0] s;
    s = 3'b000;
    hit = 2'b00;
    for (int p = 0; p < 2; p++) begin
      s = trig_sel_reg[p][2:0];
      hit[p] = trig_sel_reg[p][TME_SEL_EN_BIT] &&
               (fall[s] ? (pol_prev_reg[s] && !line_pol[s]) :
                          (!pol_prev_reg[s] && line_pol[s]));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acq_start_reg <= 2'b00;
    end else begin
      acq_start_reg <= hit;
    end
  end

  // ----------------------------------------------------------------
  // Quadrature decoder and position
  // ----------------------------------------------------------------
  assign ab_now = enc_ctrl_reg[TME_ENC_DIFF_BIT] ? clean_vec[9:8] : clean_vec[11:10];
  assign bad = (ab_now[0] != ab_prev_reg[0]) && (ab_now[1] != ab_prev_reg[1]);
  assign tick = enc_ctrl_reg[TME_ENC_EN_BIT] && (ab_now != ab_prev_reg) && !bad;
  assign up = ab_prev_reg[0] ^ ab_now[1];
  assign div_m1 = (enc_div_reg == 32'h0000_0000) ? 32'h0000_0000 :
                  enc_div_reg - 32'h0000_0001;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ab_prev_reg <= 2'b00;
    end else begin
      ab_prev_reg <= ab_now;
    end
  end

  // Clear has priority over a tick in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_reg <= 64'h0000_0000_0000_0000;
    end else if (enc_ctrl_reg[TME_ENC_CLR_BIT]) begin
      pos_reg <= 64'h0000_0000_0000_0000;
    end else if (tick) begin
      pos_reg <= up ? pos_reg + 64'h1 : pos_reg - 64'h1;
    end
  end

  // Divide-down: a divisor of zero behaves as one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg <= 32'h0000_0000;
      pulse_train_reg <= 1'b0;
    end else begin
      pulse_train_reg <= tick && (div_cnt_reg >= div_m1);
      if (enc_ctrl_reg[TME_ENC_CLR_BIT]) div_cnt_reg <= 32'h0000_0000;
      else if (tick) begin
        div_cnt_reg <= (div_cnt_reg >= div_m1) ? 32'h0000_0000 :
                       div_cnt_reg + 32'h0000_0001;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign line_out = line_out_reg;
  assign line_oe = line_oe_reg;
  assign acq_start = acq_start_reg;
  assign pulse_train = pulse_train_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  start_rise_a: assert property ((trig_sel_reg[0][3] && !fall[trig_sel_reg[0][2:0]] &&
    line_pol[trig_sel_reg[0][2:0]] && !pol_prev_reg[trig_sel_reg[0][2:0]]) |=> acq_start[0])
    else $error("rising edge did not start port 0");
  drive_level_a: assert property ((src_reg[2:0] == TME_SRC_LEVEL) |=>
    line_out[0] == $past(level_reg[0] ^ inv[0]))
    else $error("line 0 level drive wrong");
  timing_map_a: assert property ((src_reg[5:3] == TME_SRC_TIM0) |=>
    line_out[1] == $past(timing_pulse[0] ^ inv[1]))
    else $error("timing pulse not mapped to line 1");
  oe_dir_a: assert property ($fell(dir[3]) |=> !line_oe[3])
    else $error("line 3 still driven after direction set to input");
  pos_up_a: assert property ((tick && up && !enc_ctrl_reg[1]) |=>
    pos_reg == $past(pos_reg) + 64'h1)
    else $error("position did not count up");
  bad_trans_a: assert property ((bad && !enc_ctrl_reg[1]) |=> pos_reg == $past(pos_reg))
    else $error("double phase change moved the position");
  div_pulse_a: assert property ((tick && div_cnt_reg >= div_m1) |=> pulse_train ##1
    (div_cnt_reg == 32'h0000_0000 || $past(tick)))
    else $error("divided pulse missing");
  pos_read_a: assert property ((psel && penable && pready && !pwrite && ofs == TME_OFS_POS_LO
    && rd_ok && $past(setup)) |-> prdata == $past(pos_reg[31:0]))
    else $error("position low word read wrong");

  start_fall_c: cover property (fall[0] && hit[0]);
  pos_down_c: cover property (tick && !up);
  pulse_out_c: cover property (pulse_train ##[1:20] pulse_train);
  both_ports_c: cover property (acq_start == 2'b11);
endmodule

// File: sim/tme_far.sv
// Far-side model: outside drivers of the eight trigger lines and a quadrature encoder.
// Assumes the bench changes its commands just after a rising pclk edge.
`timescale 1ns/1ps
module tme_far (
  // Clock
  input wire logic pclk,
  // Line pins
  input wire logic [7:0] line_out,
  input wire logic [7:0] line_oe,
  input wire logic [7:0] ext_level,
  output logic [7:0] line_in,
  // Encoder commands
  input wire logic step,
  input wire logic down,
  input wire logic both,
  input wire logic diff_sel,
  // Encoder phases
  output logic enc_a_diff,
  output logic enc_b_diff,
  output logic enc_a_se,
  output logic enc_b_se
);
  logic a_reg = 1'b0;
  logic b_reg = 1'b0;
  logic junk_reg = 1'b0;
  // A pin shows the device's drive where enabled, else the outside source
  assign line_in = (line_oe & line_out) | (~line_oe & ext_level);
  // Gray steps; both phases flipping at once is a deliberate fault
  always @(posedge pclk) begin
    junk_reg <= ~junk_reg;
    if (both) begin
      a_reg <= ~a_reg;
      b_reg <= ~b_reg;
    end else if (step) begin
      if ((a_reg == b_reg) ^ down) begin
        b_reg <= ~b_reg;
      end else begin
        a_reg <= ~a_reg;
      end
    end
  end
  // The unused pair toggles so a wrong input choice cannot pass unseen
  assign enc_a_diff = diff_sel ? a_reg : junk_reg;
  assign enc_b_diff = diff_sel ? b_reg : junk_reg;
  assign enc_a_se = diff_sel ? junk_reg : a_reg;
  assign enc_b_se = diff_sel ? junk_reg : b_reg;
endmodule

// File: sim/trigger_mapping_and_encoder_tb.sv
// Self-checking bench for the trigger mapping and encoder block.
// Assumes tme_top and tme_far; APB slave answers with one access cycle.
`timescale 1ns/1ps
module trigger_mapping_and_encoder_tb;
  import tme_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pulse_train;
  logic [31:0] paddr, pwdata, prdata, r;
  logic [7:0] line_in, line_out, line_oe, ext_level;
  logic [1:0] timing_pulse, status_in, acq_start;
  logic ea_d, eb_d, ea_s, eb_s, step, down, both, dsel, e;
  int err_total = 0;
  int cmp_count = 0;
  int tick = 0;
  int acq0, acq1, ptc;

  tme_top u_tme_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line_in(line_in), .line_out(line_out), .line_oe(line_oe),
    .timing_pulse(timing_pulse), .status_in(status_in), .enc_a_diff(ea_d),
    .enc_b_diff(eb_d), .enc_a_se(ea_s), .enc_b_se(eb_s), .acq_start(acq_start),
    .pulse_train(pulse_train));
  tme_far u_tme_far (.pclk(pclk), .line_out(line_out), .line_oe(line_oe),
    .ext_level(ext_level), .line_in(line_in), .step(step), .down(down), .both(both),
    .diff_sel(dsel), .enc_a_diff(ea_d), .enc_b_diff(eb_d), .enc_a_se(ea_s),
    .enc_b_se(eb_s));

  // ----------------------------------------------------------------
  // Clock, pulse counters and hang guard
  // ----------------------------------------------------------------
  initial pclk = 1'b0;
  always #25 pclk = ~pclk;
  // Pulses are one cycle long, so each high sample is one event
  always @(posedge pclk) begin
    tick++;
    if (acq_start[0] === 1'b1) acq0++;
    if (acq_start[1] === 1'b1) acq1++;
    if (pulse_train === 1'b1) ptc++;
    if (tick == 20000) begin
      err_total++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("Comparisons %0d, errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] x);
    cmp_count++;
    if (g !== x) begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, g, x);
    end
  endtask
  function automatic logic [31:0] ad(input logic p, input logic [5:0] o);
    return {25'h0, p, o};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Request held until pready is seen high at a rising edge, then one idle cycle;
  // no wait-state count is assumed, only the hang guard ends a wait
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
    chk(e, 0);
  endtask
  task automatic pin(input int k, input logic v);
    ext_level[k] <= v;
    cyc(12);
  endtask
  task automatic enc(input logic d, input logic b);
    step <= 1'b1;
    down <= d;
    both <= b;
    @(posedge pclk);
    step <= 1'b0;
    both <= 1'b0;
    cyc(12);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rd(ad(0, TME_OFS_LINE_CFG), TME_RST_LINE_CFG);
    rd(ad(1, TME_OFS_ENC_DIV), TME_RST_ENC_DIV);
    rd(ad(0, TME_OFS_FILT_LEN), {24'h0, TME_RST_FILT_LEN});
    rd(ad(0, TME_OFS_POS_LO), 32'h0);
    apb(1'b1, 32'h0000_0028, 32'hffff_ffff);
    chk(e, 1);
    apb(1'b0, 32'h0000_0080, 32'h0);
    chk({r, 31'h0, e}, 64'h1);
  endtask
  // One port sets direction, the other the level and invert; port 0 reads both back
  task automatic t_drive;
    wr(ad(0, TME_OFS_LINE_CFG), 32'h0000_00ff);
    wr(ad(1, TME_OFS_LINE_LEVEL), 32'h0000_00a5);
    cyc(3);
    chk({line_oe, line_out}, 16'hffa5);
    wr(ad(1, TME_OFS_LINE_CFG), 32'h0000_0fff);
    cyc(4);
    chk(line_out, 8'haa);
    rd(ad(0, TME_OFS_LINE_CFG), 32'h0000_0fff);
    rd(ad(0, TME_OFS_LINE_STATE), 32'h0000_00a5);
    wr(ad(0, TME_OFS_LINE_CFG), 32'h0);
  endtask
  // Lines 0..6 take timing, status, pulse train and level codes 1..7
  task automatic t_src;
    wr(ad(1, TME_OFS_LINE_SRC), 32'h001e_e8d1);
    wr(ad(0, TME_OFS_LINE_LEVEL), 32'h0000_0050);
    wr(ad(0, TME_OFS_LINE_CFG), 32'h0000_007f);
    for (int p = 0; p < 4; p++) begin
      timing_pulse <= p[1:0];
      status_in <= ~p[1:0];
      cyc(3);
      chk(line_out[6:0], {3'b101, ~p[1:0], p[1:0]});
    end
    wr(ad(0, TME_OFS_LINE_CFG), 32'h0);
  endtask
  // Port 0 watches line 3 rising, port 1 line 7 falling
  task automatic t_trig;
    wr(ad(0, TME_OFS_TRIG_SEL), 32'h0000_000b);
    wr(ad(1, TME_OFS_TRIG_SEL), 32'h0000_000f);
    wr(ad(0, TME_OFS_LINE_CFG), 32'h0080_0000);
    acq0 = 0;
    acq1 = 0;
    pin(3, 1'b1);
    pin(3, 1'b0);
    pin(7, 1'b1);
    pin(7, 1'b0);
    chk({acq0[7:0], acq1[7:0]}, 16'h0101);
    pin(3, 1'b1);
    wr(ad(1, TME_OFS_LINE_CFG), 32'h0080_0800);
    pin(3, 1'b0);
    chk(acq0, 3);
    wr(ad(1, TME_OFS_LINE_CFG), 32'h0880_0800);
    ext_level[3] <= 1'b1;
    cyc(3);
    ext_level[3] <= 1'b0;
    cyc(12);
    chk(acq0, 3);
    pin(3, 1'b1);
    pin(3, 1'b0);
    chk(acq0, 4);
    wr(ad(0, TME_OFS_TRIG_SEL), 32'h0000_0003);
    pin(3, 1'b1);
    pin(3, 1'b0);
    chk(acq0, 4);
    rd(ad(1, TME_OFS_TRIG_SEL), 32'h0000_000f);
  endtask
  task automatic t_enc;
    dsel <= 1'b1;
    wr(ad(0, TME_OFS_ENC_DIV), 32'h3);
    wr(ad(0, TME_OFS_ENC_CTRL), 32'h7);
    ptc = 0;
    repeat (10) enc(1'b0, 1'b0);
    chk(ptc, 3);
    rd(ad(0, TME_OFS_POS_LO), 32'd10);
    repeat (4) enc(1'b1, 1'b0);
    enc(1'b0, 1'b1);
    rd(ad(1, TME_OFS_POS_LO), 32'd6);
    rd(ad(1, TME_OFS_POS_HI), 32'h0);
    dsel <= 1'b0;
    wr(ad(0, TME_OFS_ENC_CTRL), 32'h9);
    cyc(10);
    wr(ad(0, TME_OFS_ENC_CTRL), 32'hb);
    enc(1'b1, 1'b0);
    rd(ad(0, TME_OFS_POS_LO), 32'hffff_ffff);
    rd(ad(0, TME_OFS_POS_HI), 32'hffff_ffff);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, step, down, both, dsel} = 7'h0;
    {paddr, pwdata} = 64'h0;
    {ext_level, timing_pulse, status_in} = 12'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_drive();
    t_src();
    t_trig();
    t_enc();
    conclude();
  end
endmodule
